/* File: t16_pkg.sv */
package t16_pkg;
	// register offsets in the byte-wide register space
	localparam logic [7:0] OFS_CTRL_CLOCK = 8'h81;
	localparam logic [7:0] OFS_CTRL_FORCE = 8'h82;
	localparam logic [7:0] OFS_COUNT = 8'h84;
	localparam logic [7:0] OFS_CAPTURE = 8'h86;
	localparam logic [7:0] OFS_CMP_A = 8'h88;
	localparam logic [7:0] OFS_CMP_B = 8'h8a;
	localparam logic [7:0] OFS_HIGH = 8'h01;

	// field positions in timer_control_force
	localparam int FORCE_A_BIT = 7;
	localparam int FORCE_B_BIT = 6;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// clock select codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	// prescaler width: 1024 = 2**10
	localparam int PRESC_W = 10;

	// waveform modes that matter here
	localparam logic [3:0] WM_NORMAL = 4'h0;
	localparam logic [3:0] WM_CTC_A = 4'h4;
	localparam logic [3:0] WM_PFC_ICR = 4'h8;
	localparam logic [3:0] WM_PC_ICR = 4'ha;
	localparam logic [3:0] WM_CTC_ICR = 4'hc;
	localparam logic [3:0] WM_FAST_ICR = 4'he;

	// fixed tops
	localparam logic [15:0] TOP_MAX = 16'hffff;
	localparam logic [15:0] TOP_8BIT = 16'h00ff;
	localparam logic [15:0] TOP_9BIT = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;

	// compare output modes in non-pwm operation
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;

	// noise filter needs this many equal samples
	localparam int FILT_LEN = 4;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} t16_bus_t;

	typedef struct packed {
		logic noise_en;
		logic edge_sel;
		logic unused;
		logic [1:0] mode_hi;
		logic [2:0] clksel;
	} t16_ctrl_clock_t;
endpackage : t16_pkg

/* File: t16_core.sv */
`timescale 1ns/100ps
module t16_core
	import t16_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire t16_bus_t bus,
	output logic [7:0] rdata,
	input wire logic [1:0] waveform_mode_lo,
	input wire logic [1:0] compare_output_mode_a,
	input wire logic [1:0] compare_output_mode_b,
	input wire logic capture_from_comparator,
	input wire logic comparator_out,
	input wire logic external_count_pin,
	input wire logic capture_input_pin,
	output logic wave_out_a,
	output logic wave_out_b,
	output logic match_a,
	output logic match_b,
	output logic capture_event
);
	t16_ctrl_clock_t ctrl_reg;
	logic [15:0] count_reg, capture_reg, cmp_a_reg, cmp_b_reg;
	logic [7:0] temp_reg;
	logic [PRESC_W-1:0] presc_reg;
	logic [2:0] ext_sync_reg, cap_sync_reg;
	logic block_reg, ext_lvl_reg, ext_prev_reg;
	logic cap_lvl_reg, cap_filt_reg, cap_prev_reg;
	logic [FILT_LEN-1:0] cap_hist_reg;
	logic [3:0] mode;
	logic [15:0] top;
	logic non_pwm, icr_top, tick, ext_rise, ext_fall, wr_go, rd_go;
	logic cnt_wr, hit_a, hit_b, force_a, force_b, cap_level, cap_edge;

	// counter tick for a clock select code
	function automatic logic sel_tick(input logic [2:0] cs,
		input logic [PRESC_W-1:0] p, input logic rise, input logic fall);
		logic t;
		t = 1'b0;
		unique case (cs)
			CS_STOP: t = 1'b0;
			CS_DIV1: t = 1'b1;
			CS_DIV8: t = &p[2:0];
			CS_DIV64: t = &p[5:0];
			CS_DIV256: t = &p[7:0];
			CS_DIV1024: t = &p[9:0];
			CS_EXT_FALL: t = fall;
			CS_EXT_RISE: t = rise;
		endcase
		return t;
	endfunction : sel_tick

	// top value for a waveform mode
	function automatic logic [15:0] mode_top(input logic [3:0] m,
		input logic [15:0] ocra, input logic [15:0] icr);
		logic [15:0] v;
		v = TOP_MAX;
		unique case (m)
			4'h1, 4'h5: v = TOP_8BIT;
			4'h2, 4'h6: v = TOP_9BIT;
			4'h3, 4'h7: v = TOP_10BIT;
			4'h4, 4'h9, 4'hb, 4'hf: v = ocra;
			4'h8, 4'ha, 4'hc, 4'he: v = icr;
			default: v = TOP_MAX;
		endcase
		return v;
	endfunction : mode_top

	// new output level for a match under a compare output mode
	function automatic logic wave_next(input logic [1:0] com,
		input logic cur);
		logic v;
		v = cur;
		unique case (com)
			COM_OFF: v = cur;
			COM_TOGGLE: v = ~cur;
			COM_CLEAR: v = 1'b0;
			COM_SET: v = 1'b1;
		endcase
		return v;
	endfunction : wave_next

	assign mode = {ctrl_reg.mode_hi, waveform_mode_lo};
	assign top = mode_top(mode, cmp_a_reg, capture_reg);
	assign non_pwm = (mode == WM_NORMAL) || (mode == WM_CTC_A) ||
		(mode == WM_CTC_ICR);
	assign icr_top = (mode == WM_PFC_ICR) || (mode == WM_PC_ICR) ||
		(mode == WM_CTC_ICR) || (mode == WM_FAST_ICR);
	assign ext_rise = ext_lvl_reg & ~ext_prev_reg;
	assign ext_fall = ~ext_lvl_reg & ext_prev_reg;
	assign tick = sel_tick(ctrl_reg.clksel, presc_reg, ext_rise,
		ext_fall);
	assign wr_go = clk_en & bus.wr;
	assign rd_go = clk_en & bus.rd;
	// low-byte write commits both bytes
	assign cnt_wr = wr_go && (bus.addr == OFS_COUNT);
	assign force_a = wr_go && (bus.addr == OFS_CTRL_FORCE) &&
		bus.wdata[FORCE_A_BIT] && non_pwm;
	assign force_b = wr_go && (bus.addr == OFS_CTRL_FORCE) &&
		bus.wdata[FORCE_B_BIT] && non_pwm;
	assign hit_a = clk_en && tick && !block_reg &&
		(count_reg == cmp_a_reg);
	assign hit_b = clk_en && tick && !block_reg &&
		(count_reg == cmp_b_reg);
	assign cap_level = capture_from_comparator ? comparator_out :
		cap_filt_reg;
	assign cap_edge = clk_en && !icr_top && (cap_level != cap_prev_reg)
		&& (cap_level == ctrl_reg.edge_sel);

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			presc_reg <= '0;
		else if (clk_en)
			presc_reg <= presc_reg + 1'b1;
	end

	// pin synchronisers: a change counts once stages two and three agree
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ext_sync_reg <= 3'h0;
			ext_lvl_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			cap_sync_reg <= 3'h0;
			cap_lvl_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			ext_sync_reg <= {ext_sync_reg[1:0], external_count_pin};
			if (ext_sync_reg[1] == ext_sync_reg[2])
				ext_lvl_reg <= ext_sync_reg[2];
			ext_prev_reg <= ext_lvl_reg;
			cap_sync_reg <= {cap_sync_reg[1:0], capture_input_pin};
			if (cap_sync_reg[1] == cap_sync_reg[2])
				cap_lvl_reg <= cap_sync_reg[2];
		end
	end

	// noise filter costs latency, so it is optional
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cap_hist_reg <= '0;
			cap_filt_reg <= 1'b0;
			cap_prev_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			cap_hist_reg <= {cap_hist_reg[FILT_LEN-2:0], cap_lvl_reg};
			if (!ctrl_reg.noise_en)
				cap_filt_reg <= cap_lvl_reg;
			else if (&cap_hist_reg)
				cap_filt_reg <= 1'b1;
			else if (~|cap_hist_reg)
				cap_filt_reg <= 1'b0;
			cap_prev_reg <= cap_level;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			ctrl_reg <= RST_BYTE;
		else if (wr_go && bus.addr == OFS_CTRL_CLOCK)
			ctrl_reg <= bus.wdata;
	end

	// shared holding byte: high-byte writes and low-byte reads fill it
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			temp_reg <= RST_BYTE;
		else if (wr_go && bus.addr[0])
			temp_reg <= bus.wdata;
		else if (rd_go)
		begin
			unique case (bus.addr)
				OFS_COUNT: temp_reg <= count_reg[15:8];
				OFS_CAPTURE: temp_reg <= capture_reg[15:8];
				OFS_CMP_A: temp_reg <= cmp_a_reg[15:8];
				OFS_CMP_B: temp_reg <= cmp_b_reg[15:8];
				default: temp_reg <= temp_reg;
			endcase
		end
	end

	// a cpu write wins over a tick in the same cycle
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			count_reg <= RST_WORD;
		else if (cnt_wr)
			count_reg <= {temp_reg, bus.wdata};
		else if (clk_en && tick)
			count_reg <= (count_reg == top) ? RST_WORD :
				count_reg + 1'b1;
	end

	// stays set until the timer clock after the write has passed
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			block_reg <= 1'b0;
		else if (cnt_wr)
			block_reg <= 1'b1;
		else if (clk_en && tick)
			block_reg <= 1'b0;
	end

	// hardware capture wins over a cpu write in the same cycle
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			capture_reg <= RST_WORD;
		else if (cap_edge)
			capture_reg <= count_reg;
		else if (wr_go && bus.addr == OFS_CAPTURE)
			capture_reg <= {temp_reg, bus.wdata};
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cmp_a_reg <= RST_WORD;
			cmp_b_reg <= RST_WORD;
		end
		else if (wr_go && bus.addr == OFS_CMP_A)
			cmp_a_reg <= {temp_reg, bus.wdata};
		else if (wr_go && bus.addr == OFS_CMP_B)
			cmp_b_reg <= {temp_reg, bus.wdata};
	end

	// flag pulses come from real matches only
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			match_a <= 1'b0;
			match_b <= 1'b0;
			capture_event <= 1'b0;
		end
		else if (clk_en)
		begin
			match_a <= hit_a;
			match_b <= hit_b;
			capture_event <= cap_edge;
		end
	end

	// pwm shaping is the waveform unit's; only non-pwm modes move here
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			wave_out_a <= 1'b0;
			wave_out_b <= 1'b0;
		end
		else if (clk_en && non_pwm)
		begin
			if (hit_a || force_a)
				wave_out_a <= wave_next(compare_output_mode_a,
					wave_out_a);
			if (hit_b || force_b)
				wave_out_b <= wave_next(compare_output_mode_b,
					wave_out_b);
		end
	end

	// high bytes read back the holding byte; force bits read zero
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			rdata <= RST_BYTE;
		else if (rd_go)
		begin
			unique case (bus.addr)
				OFS_CTRL_CLOCK: rdata <= ctrl_reg;
				OFS_CTRL_FORCE: rdata <= RST_BYTE;
				OFS_COUNT: rdata <= count_reg[7:0];
				OFS_CAPTURE: rdata <= capture_reg[7:0];
				OFS_CMP_A: rdata <= cmp_a_reg[7:0];
				OFS_CMP_B: rdata <= cmp_b_reg[7:0];
				OFS_COUNT + OFS_HIGH, OFS_CAPTURE + OFS_HIGH,
				OFS_CMP_A + OFS_HIGH, OFS_CMP_B + OFS_HIGH:
					rdata <= temp_reg;
				default: rdata <= RST_BYTE;
			endcase
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence s_low_read;
		rd_go && bus.addr == OFS_COUNT && !wr_go;
	endsequence
	sequence s_high_read;
		rd_go && bus.addr == OFS_COUNT + OFS_HIGH && !wr_go;
	endsequence
	sequence s_cnt_write;
		cnt_wr;
	endsequence

	chk_stop_holds: assert property (
		ctrl_reg.clksel == CS_STOP && !cnt_wr |=> $stable(count_reg))
		else $error("counter moved with no clock source");
	chk_div8_rate: assert property (
		ctrl_reg.clksel == CS_DIV8 && clk_en && tick |->
		presc_reg[2:0] == 3'h7)
		else $error("divide by 8 tick at wrong prescaler phase");
	chk_ext_edge: assert property (
		ctrl_reg.clksel == CS_EXT_RISE && clk_en && ext_rise &&
		!cnt_wr && count_reg != top |=>
		count_reg == $past(count_reg) + 16'h0001)
		else $error("external rising edge gave no tick");
	chk_force_toggle: assert property (
		force_a && !hit_a && compare_output_mode_a == COM_TOGGLE |=>
		wave_out_a != $past(wave_out_a))
		else $error("forced match did not toggle output a");
	chk_force_no_flag: assert property (
		force_b && !hit_b |=> !match_b)
		else $error("forced match raised a match pulse");
	chk_force_reads_zero: assert property (
		rd_go && bus.addr == OFS_CTRL_FORCE |=> rdata == 8'h00)
		else $error("force register read non-zero");
	chk_temp_pairing: assert property (
		s_low_read ##1 s_high_read |=> rdata == $past(count_reg[15:8], 2))
		else $error("high byte not latched by low read");
	chk_write_block: assert property (
		s_cnt_write ##1 (clk_en && tick) |-> !hit_a && !hit_b)
		else $error("match not blocked after counter write");
	chk_capture_copy: assert property (
		cap_edge |=> capture_reg == $past(count_reg) && capture_event)
		else $error("capture did not copy the counter");
	chk_icr_top_off: assert property (
		icr_top |-> !cap_edge)
		else $error("capture fired while capture register is top");
endmodule : t16_core

/* File: t16_pin_model.sv */
`timescale 1ns/100ps
module t16_pin_model (
	input wire logic mclk,
	output logic external_count_pin,
	output logic capture_input_pin
);
	initial
	begin
		external_count_pin = 1'b0;
		capture_input_pin = 1'b0;
	end

	// pins move just after an edge, with the same lag as the bench
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : settle

	task automatic park();
		settle(1);
		external_count_pin = 1'b0;
		settle(5);
	endtask : park

	// n rising edges, left high, so only n-1 falling edges
	task automatic count_pulses(input int n);
		for (int i = 0; i < n; i++)
		begin
			settle(1);
			external_count_pin = 1'b1;
			settle(5);
			if (i < n - 1)
				external_count_pin = 1'b0;
			settle(4);
		end
	endtask : count_pulses

	task automatic capture_level(input logic lvl);
		settle(1);
		capture_input_pin = lvl;
	endtask : capture_level
endmodule : t16_pin_model

/* File: tb_timer16_clock_force_and_value_regs.sv */
`timescale 1ns/100ps
module tb_timer16_clock_force_and_value_regs;
	import t16_pkg::*;
	typedef struct {
		logic [7:0] a;
		logic [15:0] d;
		logic [15:0] e;
	} t16_row_t;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	t16_bus_t bus = '0;
	logic [7:0] rdata;
	logic [1:0] mode_lo = 2'h0;
	logic [1:0] com_a = COM_OFF;
	logic [1:0] com_b = COM_OFF;
	logic clk_en = 1'b1;
	logic cmp_sel = 1'b0;
	logic cmp_out = 1'b0;
	logic ext_pin, cap_pin, wave_a, wave_b, match_a, match_b, cap_ev;
	int n_mismatch = 0;
	int comparisons = 0;
	int n_ev[3] = '{0, 0, 0};
	int t0, t1;
	logic [15:0] v;
	logic wb;
	t16_row_t rows[6] = '{'{OFS_COUNT, 16'h1234, 16'h1234},
		'{OFS_CAPTURE, 16'hbeef, 16'hbeef}, '{OFS_CMP_A, 16'h8001, 16'h8001},
		'{OFS_CMP_B, 16'h7ffe, 16'h7ffe}, '{OFS_CTRL_FORCE, 16'h00c0, 16'h0000},
		'{OFS_CTRL_CLOCK, 16'h0000, 16'h0000}};
	int shift[6] = '{0, 0, 3, 6, 8, 10};

	always #10 mclk = ~mclk;
	always @(posedge mclk)
	begin
		n_ev[0] <= n_ev[0] + int'(cap_ev === 1'b1);
		n_ev[1] <= n_ev[1] + int'(match_a === 1'b1);
		n_ev[2] <= n_ev[2] + int'(match_b === 1'b1);
	end

	t16_core dut_u (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .bus(bus),
		.rdata(rdata), .waveform_mode_lo(mode_lo),
		.compare_output_mode_a(com_a), .compare_output_mode_b(com_b),
		.capture_from_comparator(cmp_sel), .comparator_out(cmp_out),
		.external_count_pin(ext_pin), .capture_input_pin(cap_pin),
		.wave_out_a(wave_a), .wave_out_b(wave_b), .match_a(match_a),
		.match_b(match_b), .capture_event(cap_ev));
	t16_pin_model pm_u (.mclk(mclk), .external_count_pin(ext_pin),
		.capture_input_pin(cap_pin));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h not %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1 bus = '{1'b1, 1'b0, a, d};
		@(posedge mclk);
		#1 bus.wr = 1'b0;
	endtask : wr8

	// high byte parked first, low byte commits both
	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		#1 bus = '{1'b1, 1'b0, a | OFS_HIGH, d[15:8]};
		@(posedge mclk);
		#1 bus.addr = a;
		bus.wdata = d[7:0];
		@(posedge mclk);
		#1 bus.wr = 1'b0;
	endtask : wr16

	task automatic rd16(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk);
		#1 bus = '{1'b0, 1'b1, a, 8'h00};
		@(posedge mclk);
		#1 bus.addr = a | OFS_HIGH;
		d[7:0] = rdata;
		@(posedge mclk);
		#1 bus.rd = 1'b0;
		d[15:8] = rdata;
	endtask : rd16

	// bounded wait for a new pulse; returns cycles taken
	task automatic wait_ev(input int w, input int lim, output int k);
		int b;
		b = n_ev[w];
		k = 0;
		while (n_ev[w] == b && k < lim)
		begin
			@(posedge mclk);
			k++;
		end
		#1 chk(16'(n_ev[w] - b), 16'h0001);
	endtask : wait_ev

	task automatic quiet(input int w);
		int b;
		b = n_ev[w];
		repeat (20) @(posedge mclk);
		#1 chk(16'(n_ev[w] - b), 16'h0000);
	endtask : quiet

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	initial
	begin
		repeat (100000) @(posedge mclk);
		n_mismatch++;
		end_of_test();
	end

	initial
	begin
		repeat (10) @(posedge mclk);
		#1 rst_n = 1'b1;
		foreach (rows[i])
		begin
			rd16(rows[i].a, v);
			chk(v, RST_WORD);
		end
		$display("test reset done");
		foreach (rows[i])
		begin
			wr16(rows[i].a, rows[i].d);
			rd16(rows[i].a, v);
			chk(v, rows[i].e);
		end
		repeat (50) @(posedge mclk);
		rd16(OFS_COUNT, v);
		chk(v, 16'h1234);
		// lone low write picks up whatever another register parked
		wr8(OFS_CMP_A | OFS_HIGH, 8'h5a);
		wr8(OFS_CMP_B, 8'h11);
		rd16(OFS_CMP_B, v);
		chk(v, 16'h5a11);
		$display("test table done");
		for (int c = 1; c <= 5; c++)
		begin
			wr16(OFS_COUNT, RST_WORD);
			wr8(OFS_CTRL_CLOCK, 8'(c));
			repeat (2046) @(posedge mclk);
			wr8(OFS_CTRL_CLOCK, 8'h00);
			rd16(OFS_COUNT, v);
			chk(16'((v == 16'(2048 >> shift[c])) || (v == 16'(2047 >> shift[c]))), 16'h0001);
		end
		for (int c = 6; c <= 7; c++)
		begin
			pm_u.park();
			wr16(OFS_COUNT, RST_WORD);
			wr8(OFS_CTRL_CLOCK, 8'(c));
			pm_u.count_pulses(4);
			repeat (10) @(posedge mclk);
			wr8(OFS_CTRL_CLOCK, 8'h00);
			rd16(OFS_COUNT, v);
			chk(v, (c == 7) ? 16'h0004 : 16'h0003);
		end
		$display("test clock select done");
		wr16(OFS_COUNT, 16'h0abc);
		pm_u.capture_level(1'b1);
		quiet(0);
		pm_u.capture_level(1'b0);
		wait_ev(0, 12, t0);
		rd16(OFS_CAPTURE, v);
		chk(v, 16'h0abc);
		wr16(OFS_COUNT, 16'h0def);
		wr8(OFS_CTRL_CLOCK, 8'h40);
		pm_u.capture_level(1'b1);
		wait_ev(0, 12, t0);
		rd16(OFS_CAPTURE, v);
		chk(v, 16'h0def);
		wr8(OFS_CTRL_CLOCK, 8'hc0);
		pm_u.capture_level(1'b0);
		quiet(0);
		pm_u.capture_level(1'b1);
		wait_ev(0, 20, t1);
		chk(16'((t1 - t0 == 3) || (t1 - t0 == FILT_LEN)), 16'h0001);
		wr8(OFS_CTRL_CLOCK, 8'h58);
		pm_u.capture_level(1'b0);
		quiet(0);
		pm_u.capture_level(1'b1);
		quiet(0);
		$display("test capture done");
		wr8(OFS_CTRL_CLOCK, 8'h08);
		wr16(OFS_COUNT, 16'h0005);
		com_a = COM_SET;
		com_b = COM_TOGGLE;
		wr8(OFS_CTRL_FORCE, 8'h80);
		chk(16'(wave_a), 16'h0001);
		wb = wave_b;
		wr8(OFS_CTRL_FORCE, 8'h40);
		chk(16'(wave_b), {15'h0000, ~wb});
		wb = wave_b;
		quiet(2);
		rd16(OFS_COUNT, v);
		chk(v, 16'h0005);
		mode_lo = 2'h1;
		wr8(OFS_CTRL_FORCE, 8'h40);
		mode_lo = 2'h0;
		chk(16'(wave_b), 16'(wb));
		$display("test force done");
		com_a = COM_CLEAR;
		wr8(OFS_CTRL_CLOCK, 8'h00);
		wr16(OFS_CMP_A, 16'h0010);
		wr16(OFS_CMP_B, 16'h0040);
		wr16(OFS_COUNT, RST_WORD);
		wr8(OFS_CTRL_CLOCK, {5'h00, CS_DIV1});
		wait_ev(1, 40, t0);
		chk(16'(wave_a), 16'h0000);
		// deliberate write of a running counter onto the compare value
		wr16(OFS_COUNT, 16'h0040);
		quiet(2);
		wr16(OFS_COUNT, 16'h003c);
		wait_ev(2, 10, t0);
		$display("test match done");
		// frozen cycles must neither count nor take bus writes
		wr8(OFS_CTRL_CLOCK, 8'h00);
		wr16(OFS_COUNT, RST_WORD);
		wr8(OFS_CTRL_CLOCK, {5'h00, CS_DIV1});
		clk_en = 1'b0;
		wr16(OFS_CMP_A, 16'hdead);
		repeat (27) @(posedge mclk);
		#1 clk_en = 1'b1;
		wr8(OFS_CTRL_CLOCK, 8'h00);
		rd16(OFS_COUNT, v);
		chk(v, 16'h0002);
		rd16(OFS_CMP_A, v);
		chk(v, 16'h0010);
		// comparator as capture source, rising edge selected
		wr8(OFS_CTRL_CLOCK, 8'h40);
		cmp_sel = 1'b1;
		quiet(0);
		cmp_out = 1'b1;
		wait_ev(0, 12, t0);
		rd16(OFS_CAPTURE, v);
		chk(v, 16'h0002);
		$display("test enable done");
		end_of_test();
	end
endmodule : tb_timer16_clock_force_and_value_regs
